// [verilog/remap_params.svh]
`ifndef REMAP_PARAMS_SVH
`define REMAP_PARAMS_SVH
// Processor memory address width (word address on a 16-bit bus)
`define RM_ADDR_W 16
// Translation table geometry: 4096 entries of 12 bits
`define RM_TBL_ENTRIES 4096
`define RM_TBL_AW 12
`define RM_TBL_DW 12
// Entries per direction
`define RM_HALF_ENTRIES 2048
// Decoded windows, compared on the upper address nibble
`define RM_SEL_HI 15
`define RM_SEL_LO 12
`define RM_WIN_IN 4'h4
`define RM_WIN_OUT 4'h5
`define RM_WIN_CASC 4'hA
`define RM_WIN_TBL 4'hB
// Reset values
`define RM_ENABLE_RST 1'b0
// Processor cycle timing
`define RM_CLK_NS 40
`define RM_PHASE_NS 150
`define RM_PHASE_CYC (`RM_PHASE_NS / `RM_CLK_NS)
`endif

// [verilog/remap_pkg.sv]
package remap_pkg;
`include "remap_params.svh"
   // One processor memory request
   typedef struct packed
   {
      logic req;
      logic wr;
      logic [`RM_ADDR_W-1:0] addr;
      logic [15:0] wdata;
   } cpu_req_t;
   // Access delivered to static memory
   typedef struct packed
   {
      logic en;
      logic wr;
      logic [`RM_ADDR_W-1:0] addr;
      logic [15:0] wdata;
   } mem_req_t;
   // Access delivered to the processor cascade
   typedef struct packed
   {
      logic in_wr;
      logic out_rd;
      logic [15:0] wdata;
   } casc_req_t;
   // Kinds of decoded cycle
   typedef enum logic [1:0]
   {
      CYC_MEM,
      CYC_CASC_IN,
      CYC_CASC_OUT,
      CYC_TBL
   } cyc_kind_t;
   // Phase of the remapper
   typedef enum logic [0:0]
   {
      ST_IDLE,
      ST_ACCESS
   } state_t;
endpackage : remap_pkg

// [verilog/block_move_address_remapper.sv]
`timescale 1ns/1ps
`include "remap_params.svh"
// What this block does
// - Active table replaces addresses, no extra cycles
// - Table has 4096 entries, halves per direction
// - Decode address and direction into cycle type
// - Step one reads memory via translated address
// - Step two broadcasts word to input registers
// - Step three reads last output low byte
// - Step four writes result to translated address
// - Table is 4Kx12 memory with mux, decoder
// - Direct host path only while processor disabled
// - Output read gives low byte, input accepts
// - Input register writes bypass the table
module block_move_address_remapper
   import remap_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST,
   input wire cpu_req_t CPU_REQ,
   output logic [15:0] CPU_RDATA,
   output logic CPU_ACK,
   input wire logic [15:0] MEM_RDATA,
   output mem_req_t MEM_REQ,
   output casc_req_t CASC_REQ,
   input wire logic [7:0] CASC_OUT_LOW,
   input wire logic MAP_ENABLE,
   input wire logic CPU_DISABLED,
   input wire casc_req_t HOST_CASC_REQ,
   output logic HOST_GRANT
);
   localparam int PHASE_CYC = `RM_PHASE_CYC;
   localparam logic [7:0] PHASE_LAST = 8'(PHASE_CYC - 1);
   // Acknowledge shows one edge after the done cycle
   localparam int ACK_DLY = PHASE_CYC + 1;
   // Translation table storage, 4096 x 12
   logic [`RM_TBL_DW-1:0] table_mem [0:`RM_TBL_ENTRIES-1];
   state_t state_r;
   state_t state_nxt;
   logic [7:0] cnt_r;
   logic [`RM_TBL_AW-1:0] in_idx_r;
   logic [`RM_TBL_AW-1:0] out_idx_r;
   logic enable_r;
   logic cpu_dis_s1_r;
   logic cpu_dis_r;
   cpu_req_t hold_r;
   cyc_kind_t kind_r;
   logic [`RM_TBL_DW-1:0] xlat_r;
   mem_req_t mem_r;
   casc_req_t casc_r;
   logic [15:0] rdata_r;
   logic ack_r;
   logic out_step_r;
   // Decode of the incoming request
   wire [3:0] sel = CPU_REQ.addr[`RM_SEL_HI:`RM_SEL_LO];
   wire in_win = (sel == `RM_WIN_IN);
   wire out_win = (sel == `RM_WIN_OUT);
   wire tbl_win = (sel == `RM_WIN_TBL);
   wire casc_win = (sel == `RM_WIN_CASC);
   cyc_kind_t kind_dec;
   // cycle type decode
   // The block move reads the input array then writes the output array;
   // a write into the output or cascade window feeds the cascade while out_step_r is clear,
   // a read from the input or cascade window drains it while out_step_r is set. A table-window write loads the table; everything else is plain memory.
   assign kind_dec = tbl_win && CPU_REQ.wr ? CYC_TBL :
                     (casc_win || out_win) && CPU_REQ.wr && !in_win
                        && out_step_r == 1'b0 ? CYC_CASC_IN :
                     (casc_win || in_win) && !CPU_REQ.wr
                        && out_step_r ? CYC_CASC_OUT :
                     CYC_MEM;
   // table index: low half for input, high half for output
   wire [`RM_TBL_AW-1:0] idx = CPU_REQ.wr ? out_idx_r : in_idx_r;
   wire start = (state_r == ST_IDLE) && CPU_REQ.req && !cpu_dis_r;
   wire done = (state_r == ST_ACCESS) && (cnt_r == PHASE_LAST);
   // translation applies only when table active
   wire use_map = enable_r && (kind_r == CYC_MEM);
   wire [`RM_ADDR_W-1:0] mapped =
      {hold_r.addr[`RM_ADDR_W-1:`RM_TBL_DW], xlat_r};
   // Synchronise the off-chip level inputs
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         cpu_dis_s1_r <= 1'b0;
         cpu_dis_r <= 1'b0;
         enable_r <= `RM_ENABLE_RST;
      end
      else
      begin
         cpu_dis_s1_r <= CPU_DISABLED;
         cpu_dis_r <= cpu_dis_s1_r;
         enable_r <= MAP_ENABLE;
      end
   end
   // Next state
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: if (start) state_nxt = ST_ACCESS;
         ST_ACCESS: if (done) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end
   // each half transfer lasts one phase
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         state_r <= ST_IDLE;
         cnt_r <= 8'h00;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= start || done ? 8'h00 : cnt_r + 8'h01;
      end
   end
   // Capture the request and look up its translation
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         hold_r <= '0;
         kind_r <= CYC_MEM;
         xlat_r <= '0;
      end
      else if (start)
      begin
         hold_r <= CPU_REQ;
         kind_r <= kind_dec;
         xlat_r <= table_mem[idx];
      end
   end
   always_ff @(posedge REF_CLK)
   begin
      if (start && kind_dec == CYC_TBL)
         table_mem[CPU_REQ.addr[`RM_TBL_AW-1:0]] <= CPU_REQ.wdata[11:0];
   end
   // Walk the per-direction entry counters; wraps at the half
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         in_idx_r <= '0;
         out_idx_r <= 12'(`RM_HALF_ENTRIES);
         out_step_r <= 1'b0;
      end
      else if (!enable_r)
      begin
         in_idx_r <= '0;
         out_idx_r <= 12'(`RM_HALF_ENTRIES);
         out_step_r <= 1'b0;
      end
      else if (done && kind_r != CYC_TBL)
      begin
         // Second block move of each pair drains the cascade
         if (hold_r.wr)
            out_step_r <= ~out_step_r;
         if (!hold_r.wr && kind_r == CYC_MEM)
            in_idx_r <= {1'b0, in_idx_r[10:0] + 11'h001};
         if (hold_r.wr && kind_r == CYC_MEM)
            out_idx_r <= {1'b1, out_idx_r[10:0] + 11'h001};
      end
   end
   // Drive memory and cascade strobes for the held access
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         mem_r <= '0;
         casc_r <= '0;
      end
      else if (state_r == ST_ACCESS && !done)
      begin
         mem_r.en <= (kind_r == CYC_MEM);
         mem_r.wr <= hold_r.wr && (kind_r == CYC_MEM);
         mem_r.addr <= use_map ? mapped : hold_r.addr;
         mem_r.wdata <= hold_r.wdata;
         casc_r.in_wr <= (kind_r == CYC_CASC_IN);
         // read last device output low byte
         casc_r.out_rd <= (kind_r == CYC_CASC_OUT);
         casc_r.wdata <= hold_r.wdata;
      end
      else if (cpu_dis_r)
      begin
         // host path only with processor disabled
         mem_r <= '0;
         casc_r <= HOST_CASC_REQ;
      end
      else
      begin
         mem_r <= '0;
         casc_r <= '0;
      end
   end
   // Return read data at the end of the phase
   always_ff @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         rdata_r <= 16'h0000;
         ack_r <= 1'b0;
      end
      else
      begin
         ack_r <= done;
         if (done && !hold_r.wr)
            rdata_r <= kind_r == CYC_CASC_OUT ?
               {8'h00, CASC_OUT_LOW} : MEM_RDATA;
      end
   end
   assign CPU_RDATA = rdata_r;
   assign CPU_ACK = ack_r;
   assign MEM_REQ = mem_r;
   assign CASC_REQ = casc_r;
   assign HOST_GRANT = cpu_dis_r;
   casc_no_mem_a: assert property (@(posedge REF_CLK) disable iff (RST)
      casc_r.in_wr |-> !mem_r.en) else $error("memory used on cascade write");
   // host path blocked while processor runs
   host_gate_a: assert property (@(posedge REF_CLK) disable iff (RST)
      !cpu_dis_r && state_r == ST_IDLE |=> !casc_r.in_wr && !casc_r.out_rd)
      else $error("host path used with processor enabled");
   phase_len_a: assert property (@(posedge REF_CLK) disable iff (RST)
      start |-> ##ACK_DLY CPU_ACK) else $error("phase length wrong");
   map_used_a: assert property (@(posedge REF_CLK) disable iff (RST)
      state_r == ST_ACCESS && !done && use_map |=>
      mem_r.addr[11:0] == $past(xlat_r)) else $error("address not mapped");
   casc_onehot_a: assert property (@(posedge REF_CLK) disable iff (RST)
      !(casc_r.in_wr && casc_r.out_rd)) else $error("cascade strobes clash");
   // output index stays in upper half
   out_half_a: assert property (@(posedge REF_CLK) disable iff (RST)
      out_idx_r[11] && !in_idx_r[11]) else $error("table half crossed");
   raw_addr_a: assert property (@(posedge REF_CLK) disable iff (RST)
      state_r == ST_ACCESS && !done && !enable_r && kind_r == CYC_MEM
      |=> mem_r.addr == $past(hold_r.addr)) else $error("address altered");
   low_byte_a: assert property (@(posedge REF_CLK) disable iff (RST)
      done && kind_r == CYC_CASC_OUT |=> CPU_RDATA[15:8] == 8'h00)
      else $error("high byte not clear");
   // Strobe shape of one access: raised, held, then dropped at done;
   // the counts are fixed for a three-cycle phase and do not follow RM_PHASE_CYC
   sequence mem_hold_s;
      mem_r.en [*2] ##1 !mem_r.en;
   endsequence
   sequence casc_in_hold_s;
      casc_r.in_wr [*2] ##1 !casc_r.in_wr;
   endsequence
   sequence casc_out_hold_s;
      casc_r.out_rd [*2] ##1 !casc_r.out_rd;
   endsequence
   mem_cycle_a: assert property (@(posedge REF_CLK) disable iff (RST)
      start && kind_dec == CYC_MEM |-> ##2 mem_hold_s)
      else $error("memory strobe shape wrong");
   casc_in_a: assert property (@(posedge REF_CLK) disable iff (RST)
      start && kind_dec == CYC_CASC_IN |-> ##2 casc_in_hold_s)
      else $error("cascade write strobe shape wrong");
   casc_out_a: assert property (@(posedge REF_CLK) disable iff (RST)
      start && kind_dec == CYC_CASC_OUT |-> ##2 casc_out_hold_s)
      else $error("cascade read strobe shape wrong");
   tbl_quiet_a: assert property (@(posedge REF_CLK) disable iff (RST)
      start && kind_dec == CYC_TBL |-> ##2
      !mem_r.en && !casc_r.in_wr && !casc_r.out_rd)
      else $error("table load leaked out");
   ack_pulse_a: assert property (@(posedge REF_CLK) disable iff (RST)
      CPU_ACK |=> !CPU_ACK) else $error("acknowledge longer than a cycle");
   mem_data_a: assert property (@(posedge REF_CLK) disable iff (RST)
      done && kind_r == CYC_MEM && !hold_r.wr |=>
      CPU_RDATA == $past(MEM_RDATA)) else $error("memory read data lost");
   casc_data_a: assert property (@(posedge REF_CLK) disable iff (RST)
      done && kind_r == CYC_CASC_OUT |=>
      CPU_RDATA == {8'h00, $past(CASC_OUT_LOW)})
      else $error("cascade read data lost");
   out_entry_a: assert property (@(posedge REF_CLK) disable iff (RST)
      enable_r && done && kind_r == CYC_MEM && hold_r.wr |=>
      out_idx_r == {1'b1, $past(out_idx_r[10:0]) + 11'h001})
      else $error("output entry not advanced");
   in_entry_a: assert property (@(posedge REF_CLK) disable iff (RST)
      enable_r && done && kind_r == CYC_MEM && !hold_r.wr |=>
      in_idx_r == {1'b0, $past(in_idx_r[10:0]) + 11'h001})
      else $error("input entry not advanced");
   host_pass_a: assert property (@(posedge REF_CLK) disable iff (RST)
      cpu_dis_r && state_r == ST_IDLE |=> CASC_REQ == $past(HOST_CASC_REQ))
      else $error("host request not forwarded");
endmodule : block_move_address_remapper

// [testbench/cascade_sram_model.sv]
`timescale 1ns/1ps
// Far side of the remapper: word SRAM plus a processor cascade
module cascade_sram_model
   import remap_pkg::*;
#(
   parameter logic [7:0] MIX = 8'h5A
)
(
   input wire logic ref_clk,
   input wire mem_req_t mem_req,
   output logic [15:0] mem_rdata,
   input wire casc_req_t casc_req,
   output logic [7:0] casc_out_low
);
   logic [15:0] mem_r [0:65535];
   logic [15:0] din_r = 16'h0000;
   logic [15:0] rd_last_r = 16'h0000;
   logic [7:0] out_last_r = 8'h00;
   // Idle outputs toggle so a stale value never passes for good data
   assign mem_rdata = (mem_req.en && !mem_req.wr) ?
      mem_r[mem_req.addr] : ~rd_last_r;
   assign casc_out_low = casc_req.out_rd ? din_r[7:0] ^ MIX : ~out_last_r;
   // Memory writes and the broadcast input sample
   always_ff @(posedge ref_clk)
   begin
      if (mem_req.en && mem_req.wr)
         mem_r[mem_req.addr] <= mem_req.wdata;
      if (casc_req.in_wr)
         din_r <= casc_req.wdata;
      rd_last_r <= mem_rdata;
      out_last_r <= casc_out_low;
   end
endmodule : cascade_sram_model

// [testbench/block_move_address_remapper_tb_top.sv]
`timescale 1ns/1ps
`include "remap_params.svh"
module block_move_address_remapper_tb_top
   import remap_pkg::*;
;
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
n_mismatch++; $display("Error %s expected %h seen %h", nm, e, g); end end
   typedef struct {logic map; logic wr; logic [15:0] addr;
      logic [15:0] wdata; logic [15:0] exp; logic [1:0] casc;} row_t;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   cpu_req_t cpu_req = '0;
   logic [15:0] cpu_rdata, mem_rdata, rd;
   logic cpu_ack, map_enable = 1'b0, cpu_disabled = 1'b0, host_grant;
   mem_req_t mem_req;
   casc_req_t casc_req, host_casc_req = '0;
   logic [7:0] casc_out_low;
   logic [1:0] seen;
   int n_mismatch = 0, tests_run = 0, acks = 0;
   // table loaded before the mapped rows, rows mapped to pairs
   // blocks of one word, far below the half limit
   row_t rows [12] = '{
      '{0, 1, 16'h4010, 16'h1234, 16'h0, 2'b00},
      '{0, 1, 16'h0100, 16'hABCD, 16'h0, 2'b00},
      '{0, 0, 16'h0100, 16'h0, 16'hABCD, 2'b00},
      '{0, 1, 16'hB000, 16'h0010, 16'h0, 2'b00},
      '{0, 1, 16'hB800, 16'h0020, 16'h0, 2'b00},
      '{1, 0, 16'h4000, 16'h0, 16'h1234, 2'b00},
      '{1, 1, 16'h5000, 16'h1234, 16'h0, 2'b10},
      '{1, 0, 16'h4001, 16'h0, {8'h00, 8'h34 ^ 8'h5A}, 2'b01},
      '{1, 1, 16'h5001, 16'h0077, 16'h0, 2'b00},
      '{1, 1, 16'hA000, 16'h00C3, 16'h0, 2'b10},
      '{1, 0, 16'hA001, 16'h0, {8'h00, 8'hC3 ^ 8'h5A}, 2'b01},
      '{0, 0, 16'h5020, 16'h0, 16'h0077, 2'b00}};
   block_move_address_remapper dut_u (.REF_CLK(ref_clk), .RST(rst),
      .CPU_REQ(cpu_req), .CPU_RDATA(cpu_rdata), .CPU_ACK(cpu_ack),
      .MEM_RDATA(mem_rdata), .MEM_REQ(mem_req), .CASC_REQ(casc_req),
      .CASC_OUT_LOW(casc_out_low), .MAP_ENABLE(map_enable),
      .CPU_DISABLED(cpu_disabled), .HOST_CASC_REQ(host_casc_req),
      .HOST_GRANT(host_grant));
   cascade_sram_model model_u (.ref_clk(ref_clk), .mem_req(mem_req),
      .mem_rdata(mem_rdata), .casc_req(casc_req),
      .casc_out_low(casc_out_low));
   // Free running 25 MHz clock
   always #20 ref_clk = ~ref_clk;
   // Verdict and end of run
   task automatic give_verdict();
      if (n_mismatch == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // one aligned word, held until acknowledged
   task automatic cpu_access(input row_t r, output logic [15:0] d,
      output logic [1:0] s);
      int n;
      n = 0;
      s = 2'b00;
      @(posedge ref_clk);
      #1;
      cpu_req = '{1'b1, r.wr, r.addr, r.wdata};
      while (cpu_ack !== 1'b1 && n < 20)
      begin
         @(posedge ref_clk);
         #1;
         n++;
         s = s | {casc_req.in_wr, casc_req.out_rd};
      end
      cpu_req = '0;
      `CHK("ack delay", `RM_PHASE_CYC + 1, n)
      @(posedge ref_clk);
      #1;
      d = cpu_rdata;
   endtask : cpu_access
   // Table rows, then host path, refusal and reset mid-access
   initial
   begin
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;
      foreach (rows[i])
      begin
         if (map_enable !== rows[i].map)
         begin
            map_enable = rows[i].map;
            repeat (3) @(posedge ref_clk);
         end
         cpu_access(rows[i], rd, seen);
         `CHK("cascade strobes", rows[i].casc, seen)
         if (!rows[i].wr)
            `CHK("read data", rows[i].exp, rd)
      end
      cpu_disabled = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      `CHK("host grant", 1'b1, host_grant)
      host_casc_req = '{1'b1, 1'b0, 16'h00A5};
      cpu_req = '{1'b1, 1'b0, 16'h0100, 16'h0000};
      @(posedge ref_clk);
      #1;
      `CHK("host write", host_casc_req, casc_req)
      host_casc_req = '0;
      repeat (8)
      begin
         @(posedge ref_clk);
         #1;
         if (cpu_ack !== 1'b0)
            acks++;
      end
      `CHK("refused ack", 0, acks)
      cpu_req = '0;
      cpu_disabled = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      cpu_req = '{1'b1, 1'b0, 16'h0100, 16'h0000};
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b1;
      #1;
      `CHK("reset memory", '0, mem_req)
      `CHK("reset ack", 1'b0, cpu_ack | host_grant | casc_req.in_wr)
      give_verdict();
   end
   // Watchdog against a hung handshake
   initial
   begin
      #400000;
      n_mismatch++;
      give_verdict();
   end
endmodule : block_move_address_remapper_tb_top
